// file: core/dss_shifter.sv
// dual synchronous serial shifter with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - eight bits per transfer through the buffer
// - shifting only while enable bit 2 set
// - bit 1 gates the interrupt request
// - writing start bit 3 together with enable bit 2 begins the transfer
// - start clears the 3-bit bit counter
// - completion sets pending bit 0 and requests
// - control registers reset to zero
// - zero means internal clock, receive-only, MSB-first
// - internal rate is clock/4/(prescale+1)
// - control bit picks internal or external clock
// - edge bit zero: transmit on falling edge
// - edge bit one: transmit on rising edge
// - mode bit picks transmit-receive or receive-only
// - order bit picks MSB or LSB first
module dss_shifter
  import dss_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SHIFT_CLOCK_PIN_0_I,
  output logic SHIFT_CLOCK_PIN_0_O,
  output logic SHIFT_CLOCK_PIN_0_OE,
  input wire logic SERIAL_IN_PIN_0,
  output logic SERIAL_OUT_PIN_0,
  output logic SERIAL_OUT_PIN_0_OE,
  input wire logic SHIFT_CLOCK_PIN_1_I,
  output logic SHIFT_CLOCK_PIN_1_O,
  output logic SHIFT_CLOCK_PIN_1_OE,
  input wire logic SERIAL_IN_PIN_1,
  output logic SERIAL_OUT_PIN_1,
  output logic SERIAL_OUT_PIN_1_OE,
  output logic IRQ
);

  // ****************************************************************
  // functions
  // ****************************************************************

  function automatic logic [3:0] dec_sel(input logic [AXI_AW-1:0] a);
    logic [3:0] s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      unique case (a[11:2])
        IDX_C0_CTRL: s = SEL_C0_CTRL;
        IDX_C0_BUF: s = SEL_C0_BUF;
        IDX_C0_PS: s = SEL_C0_PS;
        IDX_C1_CTRL: s = SEL_C1_CTRL;
        IDX_C1_BUF: s = SEL_C1_BUF;
        IDX_C1_PS: s = SEL_C1_PS;
        IDX_INT_STAT: s = SEL_STAT;
        IDX_INT_MASK: s = SEL_MASK;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // last divider count of one shift clock half period
  function automatic logic [9:0] half_last(input logic [7:0] ps);
    return 10'((10'(ps) + 10'h001) * HALF_MULT - 10'h001);
  endfunction

  // one system clock step of a channel's shifter
  function automatic dss_chan_t ch_step(input dss_chan_t c,
                                        input logic pin,
                                        input logic si);
    dss_chan_t n;
    logic rise;
    logic fall;
    logic smp_e;
    logic sh_e;
    n = c;
    n.done = 1'b0;
    n.pin_q = pin;
    rise = 1'b0;
    fall = 1'b0;
    if (c.st == CH_RUN) begin
      if (c.ctrl[CTL_CLKSRC]) begin
        rise = pin & ~c.pin_q;
        fall = ~pin & c.pin_q;
      end else if (c.div == half_last(c.ps)) begin
        n.div = 10'h000;
        n.sck = ~c.sck;
        rise = ~c.sck;
        fall = c.sck;
      end else begin
        n.div = c.div + 10'h001;
      end
    end else begin
      // idle level makes the first edge always the sampling one
      n.div = 10'h000;
      n.sck = c.ctrl[CTL_EDGE];
    end
    smp_e = c.ctrl[CTL_EDGE] ? fall : rise;
    sh_e = c.ctrl[CTL_EDGE] ? rise : fall;
    if (smp_e) begin
      n.rxb = si;
      n.smp = 1'b1;
    end else if (sh_e && c.smp) begin
      // a shift edge before any sample is ignored (external clock)
      n.smp = 1'b0;
      if (c.ctrl[CTL_ORDER]) begin
        n.sr = {c.rxb, c.sr[7:1]};
      end else begin
        n.sr = {c.sr[6:0], c.rxb};
      end
      n.cnt = c.cnt + 3'h1;
      if (c.cnt == LAST_BIT) begin
        n.st = CH_IDLE;
        n.ctrl[CTL_PEND] = 1'b1;
        n.done = 1'b1;
      end
    end
    return n;
  endfunction

  function automatic logic [31:0] reg_rd(input dss_state_t s,
                                         input logic [3:0] sel);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (sel)
      SEL_C0_CTRL: d[7:0] = s.ch[0].ctrl;
      SEL_C0_BUF: d[7:0] = s.ch[0].sr;
      SEL_C0_PS: d[7:0] = s.ch[0].ps;
      SEL_C1_CTRL: d[7:0] = s.ch[1].ctrl;
      SEL_C1_BUF: d[7:0] = s.ch[1].sr;
      SEL_C1_PS: d[7:0] = s.ch[1].ps;
      SEL_STAT: d[1:0] = s.stat;
      SEL_MASK: d[1:0] = s.mask;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************

  dss_state_t s_q;
  dss_state_t s_d;
  logic [1:0] pin_i;
  logic [1:0] si_i;
  logic [3:0] wsel;
  logic [7:0] wd;

  assign pin_i = {SHIFT_CLOCK_PIN_1_I, SHIFT_CLOCK_PIN_0_I};
  assign si_i = {SERIAL_IN_PIN_1, SERIAL_IN_PIN_0};

  always_comb begin
    s_d = s_q;
    wsel = SEL_NONE;
    wd = 8'h00;
    for (int k = 0; k < 2; k++) begin
      s_d.ch[k] = ch_step(s_q.ch[k], pin_i[k], si_i[k]);
    end
    // write channel: address and data taken in either order
    if (s_q.awready && S_AXI_AWVALID) begin
      s_d.aw_ok = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (s_q.wready && S_AXI_WVALID) begin
      s_d.w_ok = 1'b1;
      s_d.w_data = S_AXI_WDATA[7:0];
      s_d.w_lane = S_AXI_WSTRB[0];
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (s_d.aw_ok && s_d.w_ok && !s_d.bvalid) begin
      wsel = dec_sel(s_d.aw_addr);
      wd = s_d.w_data;
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      if (!s_d.w_lane) begin
        wsel = SEL_NONE;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (wsel == 4'(3 * k)) begin
        // start reads back as zero; a completion in this cycle wins
        s_d.ch[k].ctrl = {wd[7:4], 1'b0, wd[2:1],
                          wd[CTL_PEND] | s_d.ch[k].done};
        if (wd[CTL_START] && wd[CTL_EN]) begin
          s_d.ch[k].st = CH_RUN;
          s_d.ch[k].cnt = 3'h0;
          s_d.ch[k].smp = 1'b0;
          s_d.ch[k].div = 10'h000;
          s_d.ch[k].sck = wd[CTL_EDGE];
        end
      end
      // buffer is the shift register; not writable mid-transfer
      if (wsel == 4'(3 * k + 1) && s_d.ch[k].st == CH_IDLE) begin
        s_d.ch[k].sr = wd;
      end
      if (wsel == 4'(3 * k + 2)) begin
        s_d.ch[k].ps = wd;
      end
      if (!s_d.ch[k].ctrl[CTL_EN]) begin
        s_d.ch[k].st = CH_IDLE;
      end
      s_d.ch[k].sck_oe = ~s_d.ch[k].ctrl[CTL_CLKSRC];
      s_d.ch[k].so_oe = s_d.ch[k].ctrl[CTL_MODE];
      if (!s_d.ch[k].ctrl[CTL_MODE]) begin
        s_d.ch[k].so = 1'b0;
      end else if (s_d.ch[k].ctrl[CTL_ORDER]) begin
        s_d.ch[k].so = s_d.ch[k].sr[0];
      end else begin
        s_d.ch[k].so = s_d.ch[k].sr[7];
      end
    end
    if (wsel == SEL_STAT) begin
      s_d.stat = s_q.stat & ~wd[1:0];
    end
    if (wsel == SEL_MASK) begin
      s_d.mask = wd[1:0];
    end
    // set wins over a write-one clear in the same cycle
    for (int k = 0; k < 2; k++) begin
      if (s_d.ch[k].done && s_q.ch[k].ctrl[CTL_IE]) begin
        s_d.stat[k] = 1'b1;
      end
    end
    s_d.irq = |(s_d.stat & s_d.mask);
    // read channel
    if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && S_AXI_ARVALID) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = reg_rd(s_q, dec_sel(S_AXI_ARADDR));
      s_d.rresp = (dec_sel(S_AXI_ARADDR) == SEL_NONE) ? RESP_DECERR
                                                      : RESP_OKAY;
    end
    s_d.awready = ~s_d.aw_ok & ~s_d.bvalid;
    s_d.wready = ~s_d.w_ok & ~s_d.bvalid;
    s_d.arready = ~s_d.rvalid;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
      for (int k = 0; k < 2; k++) begin
        s_q.ch[k].ctrl <= CTRL_RST;
        s_q.ch[k].ps <= PS_RST;
        s_q.ch[k].sr <= BUF_RST;
        s_q.ch[k].sck_oe <= 1'b1;
      end
      s_q.mask <= MASK_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  assign S_AXI_AWREADY = s_q.awready;
  assign S_AXI_WREADY = s_q.wready;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_ARREADY = s_q.arready;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RDATA = s_q.rdata;
  assign S_AXI_RRESP = s_q.rresp;
  assign SHIFT_CLOCK_PIN_0_O = s_q.ch[0].sck;
  assign SHIFT_CLOCK_PIN_0_OE = s_q.ch[0].sck_oe;
  assign SERIAL_OUT_PIN_0 = s_q.ch[0].so;
  assign SERIAL_OUT_PIN_0_OE = s_q.ch[0].so_oe;
  assign SHIFT_CLOCK_PIN_1_O = s_q.ch[1].sck;
  assign SHIFT_CLOCK_PIN_1_OE = s_q.ch[1].sck_oe;
  assign SERIAL_OUT_PIN_1 = s_q.ch[1].so;
  assign SERIAL_OUT_PIN_1_OE = s_q.ch[1].so_oe;
  assign IRQ = s_q.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************

  logic [9:0] hc_q;
  logic start0_w;
  logic tog0_w;

  assign start0_w = wsel == SEL_C0_CTRL && wd[CTL_START] && wd[CTL_EN];
  assign tog0_w = SHIFT_CLOCK_PIN_0_O != s_d.ch[0].sck;

  // cycles since channel 0's clock last toggled; a restart rewinds it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hc_q <= 10'h000;
    end else if (CE) begin
      if (s_q.ch[0].st != CH_RUN || tog0_w || start0_w) begin
        hc_q <= 10'h000;
      end else begin
        hc_q <= hc_q + 10'h001;
      end
    end
  end

  default clocking cb @(posedge CLK iff CE);
  endclocking
  default disable iff (RESET);

  run_needs_en_a: assert property (
    s_q.ch[0].st == CH_RUN |-> s_q.ch[0].ctrl[CTL_EN])
    else $error("channel 0 running while disabled");

  irq_gated_a: assert property (
    $rose(s_q.stat[0]) |-> $past(s_q.ch[0].ctrl[CTL_IE]))
    else $error("status set with interrupt disabled");

  start_clear_a: assert property (
    (wsel == SEL_C0_CTRL && wd[CTL_START] && wd[CTL_EN])
      |=> s_q.ch[0].st == CH_RUN && s_q.ch[0].cnt == 3'h0)
    else $error("start did not begin a cleared transfer");

  done_pend_a: assert property (
    s_q.ch[0].done |-> s_q.ch[0].ctrl[CTL_PEND] && s_q.ch[0].st == CH_IDLE
      && $past(s_q.ch[0].cnt) == LAST_BIT)
    else $error("completion without pending or not after eighth bit");

  reset_ctrl_a: assert property (
    $fell(RESET) |-> s_q.ch[0].ctrl == CTRL_RST
      && s_q.ch[1].ctrl == CTRL_RST)
    else $error("control not zero after reset");

  clk_dir_a: assert property (
    SHIFT_CLOCK_PIN_0_OE == ~s_q.ch[0].ctrl[CTL_CLKSRC])
    else $error("clock pin direction wrong");

  rate_a: assert property (
    (s_q.ch[0].st == CH_RUN && !s_q.ch[0].ctrl[CTL_CLKSRC]
      && s_d.ch[0].st == CH_RUN && tog0_w && !start0_w)
      |-> hc_q == half_last(s_q.ch[0].ps))
    else $error("internal shift clock half period wrong");

  rx_only_a: assert property (
    !s_q.ch[0].ctrl[CTL_MODE] |-> !SERIAL_OUT_PIN_0
      && !SERIAL_OUT_PIN_0_OE)
    else $error("output driven in receive-only mode");

  msb_out_a: assert property (
    s_q.ch[0].ctrl[CTL_MODE] && !s_q.ch[0].ctrl[CTL_ORDER]
      && $stable(s_q.ch[0].ctrl) |-> SERIAL_OUT_PIN_0 == s_q.ch[0].sr[7])
    else $error("msb-first output bit wrong");

  done0_c: cover property (s_q.ch[0].done);
  done1_c: cover property (s_q.ch[1].done);
  irq_c: cover property ($rose(IRQ));
  ext_done_c: cover property (s_q.ch[0].done
    && s_q.ch[0].ctrl[CTL_CLKSRC]);

endmodule

`default_nettype wire

// file: core/dss_pkg.sv
// package: register map, field positions and state types of the dual shifter
package dss_pkg;

  localparam int AXI_AW = 12;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_C0_CTRL = 10'h0e9;
  localparam logic [9:0] IDX_C0_BUF = 10'h0ea;
  localparam logic [9:0] IDX_C0_PS = 10'h0eb;
  localparam logic [9:0] IDX_C1_CTRL = 10'h0ec;
  localparam logic [9:0] IDX_C1_BUF = 10'h0ed;
  localparam logic [9:0] IDX_C1_PS = 10'h0ee;
  localparam logic [9:0] IDX_INT_STAT = 10'h0f0;
  localparam logic [9:0] IDX_INT_MASK = 10'h0f1;

  // decoded register selects
  localparam logic [3:0] SEL_C0_CTRL = 4'h0;
  localparam logic [3:0] SEL_C0_BUF = 4'h1;
  localparam logic [3:0] SEL_C0_PS = 4'h2;
  localparam logic [3:0] SEL_C1_CTRL = 4'h3;
  localparam logic [3:0] SEL_C1_BUF = 4'h4;
  localparam logic [3:0] SEL_C1_PS = 4'h5;
  localparam logic [3:0] SEL_STAT = 4'h6;
  localparam logic [3:0] SEL_MASK = 4'h7;
  localparam logic [3:0] SEL_NONE = 4'hf;

  // control register fields
  localparam int CTL_PEND = 0;
  localparam int CTL_IE = 1;
  localparam int CTL_EN = 2;
  localparam int CTL_START = 3;
  localparam int CTL_EDGE = 4;
  localparam int CTL_ORDER = 5;
  localparam int CTL_MODE = 6;
  localparam int CTL_CLKSRC = 7;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PS_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;

  // system clock predivider ahead of the prescaler
  localparam int SYS_DIV = 4;
  localparam logic [9:0] HALF_MULT = 10'(SYS_DIV / 2);
  localparam logic [2:0] LAST_BIT = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic {CH_IDLE = 1'b0, CH_RUN = 1'b1} dss_chst_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] ps;
    logic [7:0] sr;
    logic [2:0] cnt;
    dss_chst_t st;
    logic smp;
    logic rxb;
    logic [9:0] div;
    logic sck;
    logic sck_oe;
    logic so;
    logic so_oe;
    logic pin_q;
    logic done;
  } dss_chan_t;

  typedef struct packed {
    dss_chan_t [1:0] ch;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic aw_ok;
    logic [AXI_AW-1:0] aw_addr;
    logic awready;
    logic w_ok;
    logic [7:0] w_data;
    logic w_lane;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dss_state_t;

endpackage

// file: bench/dss_serial_partner.sv
// behavioural model of the external serial device on one channel
`timescale 1ns/1ps
`default_nettype none
module dss_serial_partner #(
  parameter int HALF = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic so,
  input wire logic idle,
  input wire logic lsb,
  input wire logic load,
  input wire logic go,
  input wire logic [7:0] word,
  output logic si,
  output logic sck_drv,
  output logic [7:0] rx
);
  // ****************************************
  // shifter and clock source
  // ****************************************
  logic [7:0] sr;
  logic [3:0] n;
  logic prev;
  logic [4:0] tog;
  int tm;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr <= 8'h00;
      n <= 4'h8;
      prev <= 1'b0;
      tog <= 5'h00;
      tm <= 0;
      sck_drv <= 1'b0;
      si <= 1'b0;
      rx <= 8'h00;
    end else begin
      prev <= sck;
      if (load) begin
        sr <= word;
        n <= 4'h0;
        si <= lsb ? word[0] : word[7];
      end else if (sck != prev && sck != idle) begin
        rx <= lsb ? {so, rx[7:1]} : {rx[6:0], so};
      end else if (sck != prev && n < 4'h8) begin
        sr <= lsb ? sr >> 1 : sr << 1;
        n <= n + 4'h1;
        // line inverted after the last bit: no stale level left behind
        si <= (n == 4'h7) ? ~si : (lsb ? sr[1] : sr[6]);
      end
      // clock stands at idle outside frames
      if (go) begin
        tog <= 5'h10;
        tm <= 0;
        sck_drv <= idle;
      end else if (tog != 5'h00) begin
        if (tm == HALF - 1) begin
          tm <= 0;
          sck_drv <= ~sck_drv;
          tog <= tog - 5'h01;
        end else begin
          tm <= tm + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/test_dual_sync_serial_shifter.sv
// self-checking bench for the dual serial shifter
`timescale 1ns/1ps
`default_nettype none
module test_dual_sync_serial_shifter import dss_pkg::*; ;
  // ****************************************
  // signals and instances
  // ****************************************
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r;
    logic [1:0] br;
    logic [1:0] rr;
  } dss_row_t;
  localparam logic [11:0] C0 = {IDX_C0_CTRL, 2'h0};
  localparam logic [11:0] B0 = {IDX_C0_BUF, 2'h0};
  localparam logic [11:0] P0 = {IDX_C0_PS, 2'h0};
  localparam logic [11:0] C1 = {IDX_C1_CTRL, 2'h0};
  localparam logic [11:0] B1 = {IDX_C1_BUF, 2'h0};
  localparam logic [11:0] P1 = {IDX_C1_PS, 2'h0};
  localparam logic [11:0] ST = {IDX_INT_STAT, 2'h0};
  localparam logic [11:0] MK = {IDX_INT_MASK, 2'h0};
  logic clk, rst, aw_v, w_v, ar_v, aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
  logic [11:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, got;
  logic [1:0] b_rs, r_rs, rs, p_load;
  logic shift_clock_pin_0_o, shift_clock_pin_0_oe, so0, so0_oe, shift_clock_pin_1_o, shift_clock_pin_1_oe, so1, so1_oe;
  logic si0, si1, d0, d1, p_idle, p_lsb, p_go, shift_clock_pin_0_p, so0_p, edge_sel;
  logic [7:0] p_word, rx0, rx1;
  logic ce, b_r, r_r;
  logic [3:0] w_s;
  int fail_count, compares, k, r0, b0, r1;
  int cyc = 0, last = 0, per = 0, rises = 0, bad = 0;
  wire shift_clock_pin_0 = shift_clock_pin_0_oe ? shift_clock_pin_0_o : d0;
  wire shift_clock_pin_1 = shift_clock_pin_1_oe ? shift_clock_pin_1_o : d1;
  dss_row_t rows [9] = '{'{P0, 32'ha5, 32'ha5, 2'h0, 2'h0},
    '{P1, 32'h3c, 32'h3c, 2'h0, 2'h0}, '{MK, 32'h3, 32'h3, 2'h0, 2'h0},
    '{MK, 32'h0, 32'h0, 2'h0, 2'h0}, '{C1, 32'h72, 32'h72, 2'h0, 2'h0},
    '{C1, 32'h0, 32'h0, 2'h0, 2'h0}, '{B0, 32'h11, 32'h11, 2'h0, 2'h0},
    '{12'h3e0, 32'hff, 32'h0, 2'h3, 2'h3},
    '{12'h3a5, 32'hff, 32'h0, 2'h3, 2'h3}};
  dss_shifter dut_u (.CLK(clk), .RESET(rst), .CE(ce),
    .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
    .S_AXI_WDATA(w_d), .S_AXI_WSTRB(w_s), .S_AXI_WVALID(w_v),
    .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_rs), .S_AXI_BVALID(b_v),
    .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v),
    .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_rs),
    .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .SHIFT_CLOCK_PIN_0_I(shift_clock_pin_0),
    .SHIFT_CLOCK_PIN_0_O(shift_clock_pin_0_o), .SHIFT_CLOCK_PIN_0_OE(shift_clock_pin_0_oe),
    .SERIAL_IN_PIN_0(si0), .SERIAL_OUT_PIN_0(so0),
    .SERIAL_OUT_PIN_0_OE(so0_oe),
    .SHIFT_CLOCK_PIN_1_I(shift_clock_pin_1), .SHIFT_CLOCK_PIN_1_O(shift_clock_pin_1_o),
    .SHIFT_CLOCK_PIN_1_OE(shift_clock_pin_1_oe), .SERIAL_IN_PIN_1(si1),
    .SERIAL_OUT_PIN_1(so1), .SERIAL_OUT_PIN_1_OE(so1_oe), .IRQ(irq));
  dss_serial_partner #(.HALF(2)) p0_u (.clk(clk), .rst(rst), .sck(shift_clock_pin_0),
    .so(so0), .idle(p_idle), .lsb(p_lsb), .load(p_load[0]), .go(1'b0),
    .word(p_word), .si(si0), .sck_drv(d0), .rx(rx0));
  dss_serial_partner #(.HALF(5)) p1_u (.clk(clk), .rst(rst), .sck(shift_clock_pin_1),
    .so(so1), .idle(p_idle), .lsb(p_lsb), .load(p_load[1]), .go(p_go),
    .word(p_word), .si(si1), .sck_drv(d1), .rx(rx1));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // edge watch: a data change off the transmit phase is counted as bad
  always @(posedge clk) begin
    shift_clock_pin_0_p <= shift_clock_pin_0_o;
    so0_p <= so0;
    cyc <= cyc + 1;
    if (shift_clock_pin_0_o && !shift_clock_pin_0_p) begin
      rises <= rises + 1;
      per <= cyc - last;
      last <= cyc;
    end
    if (so0_oe && so0 != so0_p && shift_clock_pin_0_o != edge_sel) bad <= bad + 1;
  end
  // ****************************************
  // tasks
  // ****************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task tmo(input int i);
    if (i >= 300) begin
      fail_count++;
      stop_test;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge clk);
      i++;
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (b_v !== 1'b1 && i < 300);
    rs = b_rs;
    tmo(i);
  endtask
  task rd(input logic [11:0] a);
    int i;
    i = 0;
    ar_a <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge clk);
      i++;
      if (ar_rdy) ar_v <= 1'b0;
    end while (r_v !== 1'b1 && i < 300);
    got = r_d;
    rs = r_rs;
    tmo(i);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wirq;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (irq !== 1'b1 && i < 300);
    tmo(i);
  endtask
  task wpend(input logic [11:0] a);
    int i;
    i = 0;
    do begin
      rd(a);
      i++;
    end while (got[0] !== 1'b1 && i < 300);
    tmo(i);
  endtask
  task pload(input int c, input logic [7:0] w, input logic id, input logic l);
    p_word <= w;
    p_idle <= id;
    p_lsb <= l;
    p_load[c] <= 1'b1;
    @(posedge clk);
    p_load <= 2'h0;
    r0 = rises;
    b0 = bad;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {aw_v, w_v, ar_v, p_go, edge_sel} = 5'h00;
    {ce, b_r, r_r, w_s} = 7'h7f;
    {aw_a, ar_a, w_d, p_word, p_load, p_idle, p_lsb} = '0;
    {fail_count, compares} = '0;
    wt(6);
    rst <= 1'b0;
    wt(1);
    for (k = 0; k < 9; k++) begin
      wr(rows[k].a, rows[k].w);
      chk(rs, rows[k].br);
      rd(rows[k].a);
      chk(got, rows[k].r);
      chk(rs, rows[k].rr);
    end
    // a write without lane 0 is answered but changes nothing
    w_s <= 4'he;
    wr(P1, 32'h77);
    w_s <= 4'hf;
    chk(rs, 2'h0);
    rd(P1);
    chk(got, 32'h3c);
    $display("test registers done");
    wr(P0, 32'h1);
    wr(MK, 32'h1);
    wr(B0, 32'ha5);
    wr(C0, 32'h46);
    pload(0, 8'h3c, 1'b0, 1'b0);
    wr(C0, 32'h4e);
    wirq;
    chk(rises - r0, 8);
    chk(per, 8);
    chk(bad - b0, 0);
    chk(rx0, 8'ha5);
    rd(B0);
    chk(got, 32'h3c);
    rd(C0);
    chk(got, 32'h47);
    rd(ST);
    chk(got, 32'h1);
    wr(ST, 32'h1);
    wt(2);
    chk(irq, 1'b0);
    $display("test msb_falling done");
    edge_sel <= 1'b1;
    wr(P0, 32'h0);
    wr(C0, 32'h74);
    wr(B0, 32'h96);
    pload(0, 8'h5a, 1'b1, 1'b1);
    wr(C0, 32'h7c);
    wpend(C0);
    chk(got, 32'h75);
    chk(rises - r0, 8);
    chk(bad - b0, 0);
    chk(rx0, 8'h96);
    rd(B0);
    chk(got, 32'h5a);
    rd(ST);
    chk(got, 32'h0);
    chk(irq, 1'b0);
    $display("test lsb_rising done");
    edge_sel <= 1'b0;
    wr(P0, 32'h3);
    wr(C0, 32'h40);
    r0 = rises;
    wr(C0, 32'h48);
    wt(60);
    rd(C0);
    chk(got, 32'h40);
    chk(rises - r0, 0);
    // receive-only restart, then a clock-enable freeze mid-frame
    wr(C0, 32'h0c);
    wt(20);
    pload(0, 8'he7, 1'b0, 1'b0);
    wr(C0, 32'h0c);
    r0 = rises;
    ce <= 1'b0;
    wt(2);
    r1 = rises;
    wt(20);
    chk(rises - r1, 0);
    chk(so0_oe, 1'b0);
    ce <= 1'b1;
    wpend(C0);
    chk(got, 32'h05);
    chk(rises - r0, 8);
    rd(B0);
    chk(got, 32'he7);
    $display("test restart done");
    wr(MK, 32'h2);
    wr(C1, 32'hc6);
    wt(2);
    chk(shift_clock_pin_1_oe, 1'b0);
    chk(so1_oe, 1'b1);
    wr(B1, 32'hc3);
    pload(1, 8'h69, 1'b0, 1'b0);
    wr(C1, 32'hce);
    p_go <= 1'b1;
    wt(1);
    p_go <= 1'b0;
    wirq;
    chk(rx1, 8'hc3);
    rd(B1);
    chk(got, 32'h69);
    rd(ST);
    chk(got, 32'h2);
    rd(C1);
    chk(got, 32'hc7);
    $display("test external_clock done");
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    wt(1);
    chk(shift_clock_pin_0_oe, 1'b1);
    chk(so0_oe, 1'b0);
    chk(irq, 1'b0);
    rd(C0);
    chk(got, 32'h0);
    rd(C1);
    chk(got, 32'h0);
    $display("test reset done");
    stop_test;
  end
endmodule
`default_nettype wire
